// ===== hdl/rog_pkg.sv
package rog_pkg;

    // ************************************************************
    // register offsets
    // ************************************************************
    localparam logic [7:0] OFS_DATA = 8'h00;
    localparam logic [7:0] OFS_CTRL = 8'h04;
    localparam logic [7:0] OFS_STAT = 8'h08;
    localparam logic [7:0] OFS_FLVL = 8'h0c;
    localparam logic [7:0] OFS_FTHR = 8'h10;
    localparam logic [7:0] OFS_MODE = 8'h14;

    // ************************************************************
    // field positions and reset values
    // ************************************************************
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_DRIE_BIT = 1;
    localparam int CTRL_ERIE_BIT = 2;
    localparam int CTRL_ROEN_LSB = 8;
    localparam int STAT_DATA_READY_FLAG_BIT = 0;
    localparam int STAT_ERR_BIT = 1;
    localparam int MODE_DET_BIT = 0;
    localparam int NUM_RO = 4;
    localparam int THR_W = 4;
    localparam logic CTRL_DRIE_RST = 1'b1;
    localparam logic CTRL_ERIE_RST = 1'b0;
    localparam logic [3:0] ROEN_RST = 4'hf;
    localparam logic [3:0] FTHR_RST = 4'h4;
    localparam logic [31:0] POST_SEED = 32'h0000_0001;
    localparam int FIFO_DEPTH_DEF = 8;

    // ************************************************************
    // bus carriers and states
    // ************************************************************
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } rog_apb_req_s;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } rog_apb_rsp_s;

    typedef enum logic [0:0] {
        BUS_IDLE = 1'b0,
        BUS_ACK = 1'b1
    } rog_bus_e;

endpackage

// ===== hdl/rog_random_generator_core.sv
`timescale 1ns/1ns
module rog_random_generator_core
    import rog_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH_DEF
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // register bus
    input wire rog_apb_req_s apb_req,
    output rog_apb_rsp_s apb_rsp,
    // entropy source pins
    input wire logic [NUM_RO-1:0] ro_osc,
    input wire logic sclk_sel,
    output logic [NUM_RO-1:0] ro_en,
    // interrupt lines
    output logic irq_data_ready,
    output logic irq_empty_read
);

    localparam int AW = $clog2(DEPTH);
    localparam int LW = $clog2(DEPTH + 1);

    // threshold field is four bits and pointers wrap by power of two
    if (DEPTH < 2 || DEPTH > 8 || (DEPTH & (DEPTH - 1)) != 0) begin : g_depth_bad
        $error("DEPTH must be a power of two from 2 to 8");
    end

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        rog_bus_e bus;
        logic [31:0] prdata;
        logic pslverr;
        logic rd_empty;
        logic gen_en;
        logic drie;
        logic erie;
        logic [NUM_RO-1:0] roen;
        logic [THR_W-1:0] thr;
        logic det_mode;
        logic data_ready_flag;
        logic erflag;
        logic irq_dr;
        logic irq_er;
        logic [NUM_RO:0] sync1;
        logic [NUM_RO:0] sync2;
        logic [NUM_RO-1:0] osc_prev;
        logic [31:0] shreg;
        logic [4:0] bitcnt;
        logic [31:0] post;
        logic [DEPTH-1:0][31:0] mem;
        logic [AW-1:0] wptr;
        logic [AW-1:0] rptr;
        logic [LW-1:0] level;
    } rog_state_s;

    rog_state_s s_r;
    rog_state_s s_nxt;

    // one mixing round of the deterministic stage
    function automatic logic [31:0] post_mix(input logic [31:0] st, input logic [31:0] raw);
        logic [31:0] x;
        x = st ^ raw;
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        x = x ^ (x << 5);
        return x;
    endfunction

    // register offset decode, shared by read and write paths
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        return a == ofs;
    endfunction

    // ************************************************************
    // next-state logic
    // ************************************************************
    logic ack;
    logic rd_data;
    logic push;
    logic pop;
    logic wr_stat;
    logic [31:0] word;
    logic [NUM_RO-1:0] smp_bit;
    logic [NUM_RO-1:0] smp_hit;
    logic raw_bit;
    logic raw_stb;
    logic [LW-1:0] lvl_n;
    logic [7:0] adr;
    logic [31:0] wd;

    always_comb begin
        s_nxt = s_r;
        adr = apb_req.paddr;
        wd = apb_req.pwdata;
        ack = apb_req.psel && apb_req.penable && s_r.bus == BUS_ACK;
        rd_data = ack && !apb_req.pwrite && hit(adr, OFS_DATA);
        wr_stat = ack && apb_req.pwrite && hit(adr, OFS_STAT);
        // pins pass two flops; sclk_sel rides in the top bit
        s_nxt.sync1 = {sclk_sel, ro_osc};
        s_nxt.sync2 = s_r.sync1;
        s_nxt.osc_prev = s_r.sync2[NUM_RO-1:0];
        // own-clock sampling takes the neighbour's phase at each own rising edge
        for (int i = 0; i < NUM_RO; i++) begin
            smp_hit[i] = s_r.roen[i] &&
                (s_r.sync2[NUM_RO] || (s_r.sync2[i] && !s_r.osc_prev[i]));
            smp_bit[i] = s_r.sync2[NUM_RO] ? s_r.sync2[i] : s_r.sync2[(i + 1) % NUM_RO];
        end
        raw_stb = s_r.gen_en && |smp_hit;
        raw_bit = ^(smp_bit & smp_hit);
        word = 32'h0;
        push = 1'b0;
        if (raw_stb) begin
            s_nxt.shreg = {s_r.shreg[30:0], raw_bit};
            s_nxt.bitcnt = s_r.bitcnt + 5'h01;
            if (s_r.bitcnt == 5'h1f) begin
                // raw word always runs the mixer; mode picks what is queued
                s_nxt.post = post_mix(s_r.post, {s_r.shreg[30:0], raw_bit});
                word = s_r.det_mode ? s_nxt.post : {s_r.shreg[30:0], raw_bit};
                push = LW'(DEPTH) != s_r.level; // a full queue drops the word
            end
        end
        pop = rd_data && !s_r.rd_empty;
        if (push) begin
            s_nxt.mem[s_r.wptr] = word;
            s_nxt.wptr = s_r.wptr + AW'(1);
        end
        if (pop) begin
            s_nxt.rptr = s_r.rptr + AW'(1);
        end
        lvl_n = s_r.level + LW'(push) - LW'(pop);
        s_nxt.level = lvl_n;
        // bus: one wait state so read data comes from a flop
        unique case (s_r.bus)
            BUS_IDLE: begin
                if (apb_req.psel && apb_req.penable) begin
                    s_nxt.bus = BUS_ACK;
                    s_nxt.pslverr = !(hit(adr, OFS_DATA) || hit(adr, OFS_CTRL) ||
                        hit(adr, OFS_STAT) || hit(adr, OFS_FLVL) ||
                        hit(adr, OFS_FTHR) || hit(adr, OFS_MODE));
                    s_nxt.prdata = 32'h0;
                    // judged at capture: a push before the ack must not pop an unsent word
                    s_nxt.rd_empty = s_r.level == '0;
                    if (!apb_req.pwrite) begin
                        if (hit(adr, OFS_DATA)) begin
                            // empty read returns zero
                            s_nxt.prdata = s_r.level != '0 ? s_r.mem[s_r.rptr] : 32'h0;
                        end else if (hit(adr, OFS_CTRL)) begin
                            s_nxt.prdata[CTRL_EN_BIT] = s_r.gen_en;
                            s_nxt.prdata[CTRL_DRIE_BIT] = s_r.drie;
                            s_nxt.prdata[CTRL_ERIE_BIT] = s_r.erie;
                            s_nxt.prdata[CTRL_ROEN_LSB +: NUM_RO] = s_r.roen;
                        end else if (hit(adr, OFS_STAT)) begin
                            s_nxt.prdata[STAT_DATA_READY_FLAG_BIT] = s_r.data_ready_flag;
                            s_nxt.prdata[STAT_ERR_BIT] = s_r.erflag;
                        end else if (hit(adr, OFS_FLVL)) begin
                            s_nxt.prdata[LW-1:0] = s_r.level;
                        end else if (hit(adr, OFS_FTHR)) begin
                            s_nxt.prdata[THR_W-1:0] = s_r.thr;
                        end else if (hit(adr, OFS_MODE)) begin
                            s_nxt.prdata[MODE_DET_BIT] = s_r.det_mode;
                        end
                    end
                end
            end
            BUS_ACK: begin
                s_nxt.bus = BUS_IDLE;
                // error response stands for the completing cycle only
                s_nxt.pslverr = 1'b0;
            end
        endcase
        // register writes take effect at the completing edge
        if (ack && apb_req.pwrite) begin
            if (hit(adr, OFS_CTRL)) begin
                s_nxt.gen_en = wd[CTRL_EN_BIT];
                // running generator keeps its setup
                if (!s_r.gen_en) begin
                    s_nxt.drie = wd[CTRL_DRIE_BIT];
                    s_nxt.erie = wd[CTRL_ERIE_BIT];
                    s_nxt.roen = wd[CTRL_ROEN_LSB +: NUM_RO];
                end
            end
            if (hit(adr, OFS_FTHR) && !s_r.gen_en) begin
                s_nxt.thr = wd[THR_W-1:0];
            end
            if (hit(adr, OFS_MODE)) begin
                s_nxt.det_mode = wd[MODE_DET_BIT];
            end
        end
        // write-one clears only act while enabled
        if (wr_stat && s_r.gen_en && wd[STAT_DATA_READY_FLAG_BIT]) begin
            s_nxt.data_ready_flag = 1'b0;
        end
        if (wr_stat && s_r.gen_en && wd[STAT_ERR_BIT]) begin
            s_nxt.erflag = 1'b0;
        end
        // sets come last so an event beats a clear in the same cycle
        if (push && !pop && int'(lvl_n) == int'(s_r.thr)) begin
            s_nxt.data_ready_flag = 1'b1;
        end
        if (rd_data && s_r.rd_empty) begin
            s_nxt.erflag = 1'b1;
        end
        s_nxt.irq_dr = s_nxt.data_ready_flag && s_nxt.drie;
        s_nxt.irq_er = s_nxt.erflag && s_nxt.erie;
    end

    // ************************************************************
    // state register
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '0;
            s_r.drie <= CTRL_DRIE_RST;
            s_r.erie <= CTRL_ERIE_RST;
            s_r.roen <= ROEN_RST;
            s_r.thr <= FTHR_RST;
            s_r.post <= POST_SEED;
        end else begin
            s_r <= s_nxt;
        end
    end

    // outputs straight from the state flops
    assign apb_rsp.prdata = s_r.prdata;
    assign apb_rsp.pready = s_r.bus == BUS_ACK;
    assign apb_rsp.pslverr = s_r.pslverr;
    assign ro_en = s_r.roen;
    assign irq_data_ready = s_r.irq_dr;
    assign irq_empty_read = s_r.irq_er;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_empty_read;
        rd_data && s_r.rd_empty;
    endsequence

    sequence s_clear_err;
        wr_stat && s_r.gen_en && apb_req.pwdata[STAT_ERR_BIT];
    endsequence

    sequence s_clear_data_ready_flag;
        wr_stat && s_r.gen_en && apb_req.pwdata[STAT_DATA_READY_FLAG_BIT];
    endsequence

    a_data_ready_flag_rise_cause: assert property ($rose(s_r.data_ready_flag) |->
        int'(s_r.level) == int'(s_r.thr) && s_r.level == $past(s_r.level) + LW'(1))
        else $error("data ready rose off threshold");
    a_flag_held_off: assert property (!s_r.gen_en && s_r.erflag |=> s_r.erflag)
        else $error("error flag cleared while disabled");
    a_data_ready_flag_held_off: assert property (!s_r.gen_en && s_r.data_ready_flag |=> s_r.data_ready_flag)
        else $error("data ready cleared while disabled");
    a_empty_read_flag: assert property (s_empty_read |=>
        s_r.erflag ##1 irq_empty_read == s_r.erie) else $error("empty read not flagged");
    a_empty_data_zero: assert property (s_empty_read |-> apb_rsp.prdata == 32'h0)
        else $error("empty read returned data");
    a_err_clear: assert property (s_clear_err |=> !s_r.erflag)
        else $error("error flag not cleared");
    a_data_ready_flag_clear: assert property (s_clear_data_ready_flag ##0 !push |=> !s_r.data_ready_flag)
        else $error("data ready not cleared");
    a_pop_level: assert property (rd_data && !s_r.rd_empty && !push
        |=> s_r.level + LW'(1) == $past(s_r.level)) else $error("read did not pop");
    a_level_bound: assert property (int'(s_r.level) <= DEPTH)
        else $error("level beyond depth");
    a_cfg_locked: assert property (s_r.gen_en && ack && apb_req.pwrite
        |=> $stable(s_r.thr) && $stable(ro_en)) else $error("config changed while running");
    a_mode_switch: assert property (ack && apb_req.pwrite
        && hit(apb_req.paddr, OFS_MODE) |=> s_r.det_mode == $past(apb_req.pwdata[MODE_DET_BIT]))
        else $error("mode not taken");
    a_bus_wait: assert property (apb_req.psel && apb_req.penable && !apb_rsp.pready
        |=> apb_rsp.pready) else $error("no answer after one wait");

endmodule

// ===== tb/rog_ro_model.sv
`timescale 1ns/1ns
module rog_ro_model
    import rog_pkg::*;
(
    // oscillator side
    input wire logic [NUM_RO-1:0] ro_en,
    output logic [NUM_RO-1:0] ro_osc
);
    // each ring toggles at its own odd period so no two stay in step with the clock
    // a disabled ring stops low, as a gated inverter chain would
    for (genvar i = 0; i < NUM_RO; i++) begin : g_ro
        initial begin
            ro_osc[i] = 1'b0;
            forever begin
                #(3 + 2 * i);
                ro_osc[i] = ro_en[i] ? ~ro_osc[i] : 1'b0;
            end
        end
    end
endmodule

// ===== tb/ring_osc_random_bit_generator_tb.sv
`timescale 1ns/1ns
module ring_osc_random_bit_generator_tb
    import rog_pkg::*;
;
    localparam int DEP = 8;
    logic pclk;
    logic presetn;
    rog_apb_req_s apb_req;
    rog_apb_rsp_s apb_rsp;
    logic [NUM_RO-1:0] ro_osc;
    logic [NUM_RO-1:0] ro_en;
    logic sclk_sel;
    logic irq_data_ready;
    logic irq_empty_read;
    logic last_err;
    logic [31:0] rd_q;
    int error_cnt = 0;
    int n_checks = 0;
    int cyc = 0;

    rog_random_generator_core #(.DEPTH(DEP)) dut_u (
        .pclk(pclk),
        .presetn(presetn),
        .apb_req(apb_req),
        .apb_rsp(apb_rsp),
        .ro_osc(ro_osc),
        .sclk_sel(sclk_sel),
        .ro_en(ro_en),
        .irq_data_ready(irq_data_ready),
        .irq_empty_read(irq_empty_read)
    );

    rog_ro_model ro_u (
        .ro_en(ro_en),
        .ro_osc(ro_osc)
    );

    // ************************************************************
    // clock, timeout and report
    // ************************************************************
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    // the whole sequence needs well under 3000 cycles
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            results();
        end
    end

    task automatic results();
        $display("checks=%0d errors=%0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // ************************************************************
    // apb master: one idle edge first so no signal is assigned twice
    // ************************************************************
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge pclk);
        apb_req.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (apb_rsp.pready !== 1'b1 && n < 50);
        rd_q = apb_rsp.prdata;
        last_err = apb_rsp.pslverr;
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
        chk({31'h0, apb_rsp.pready}, 32'h1);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        chk(rd_q & m, e);
    endtask

    // bounded wait for the data-ready line
    task automatic wait_dr(input int lim);
        int n;
        n = 0;
        while (irq_data_ready !== 1'b1 && n < lim) begin
            @(posedge pclk);
            n++;
        end
        chk({31'h0, irq_data_ready}, 32'h1);
    endtask

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        apb_req = '0;
        presetn = 1'b0;
        sclk_sel = 1'b1;
        last_err = 1'b0;
        rd_q = '0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        chk({28'h0, ro_en}, 32'hf);
        rd_chk(OFS_CTRL, 32'hffff_ffff, 32'h0000_0f02);
        rd_chk(OFS_FTHR, 32'hf, 32'h4);
        rd_chk(OFS_FLVL, 32'hff, 32'h0);
        xfer(1'b0, 8'h18, 32'h0);
        chk({31'h0, last_err}, 32'h1);
        // idle and empty: a data read flags the error, which cannot clear yet
        xfer(1'b1, OFS_CTRL, 32'h0000_0f06);
        rd_chk(OFS_DATA, 32'hffff_ffff, 32'h0);
        rd_chk(OFS_STAT, 32'h3, 32'h2);
        chk({31'h0, irq_empty_read}, 32'h1);
        xfer(1'b1, OFS_STAT, 32'h2);
        rd_chk(OFS_STAT, 32'h3, 32'h2);
        // enable, then clear the stale error before traffic builds up
        xfer(1'b1, OFS_CTRL, 32'h0000_0f07);
        xfer(1'b1, OFS_STAT, 32'h2);
        rd_chk(OFS_STAT, 32'h2, 32'h0);
        chk({31'h0, irq_empty_read}, 32'h0);
        // configuration is locked while running, mode is not
        xfer(1'b1, OFS_FTHR, 32'h2);
        xfer(1'b1, OFS_CTRL, 32'h0000_0007);
        rd_chk(OFS_FTHR, 32'hf, 32'h4);
        rd_chk(OFS_CTRL, 32'hf07, 32'hf07);
        chk({28'h0, ro_en}, 32'hf);
        xfer(1'b1, OFS_MODE, 32'h1);
        rd_chk(OFS_MODE, 32'h1, 32'h1);
        // the line rises with exactly the threshold held
        wait_dr(400);
        rd_chk(OFS_FLVL, 32'hff, 32'h4);
        rd_chk(OFS_STAT, 32'h1, 32'h1);
        // cleared above threshold it stays low while the fifo fills up
        repeat (70) @(posedge pclk);
        xfer(1'b1, OFS_STAT, 32'h1);
        @(posedge pclk); // the clear lands on the completing edge
        chk({31'h0, irq_data_ready}, 32'h0);
        repeat (100) @(posedge pclk);
        chk({31'h0, irq_data_ready}, 32'h0);
        rd_chk(OFS_FLVL, 32'hff, DEP);
        // a burst of the reported count never reads empty
        repeat (DEP) xfer(1'b0, OFS_DATA, 32'h0);
        rd_chk(OFS_STAT, 32'h2, 32'h0);
        wait_dr(400);
        // stop first: enables written while running would be ignored
        xfer(1'b1, OFS_CTRL, 32'h0000_0502);
        xfer(1'b1, OFS_STAT, 32'h1);
        rd_chk(OFS_STAT, 32'h1, 32'h1);
        xfer(1'b1, OFS_CTRL, 32'h0000_0502);
        @(posedge pclk);
        chk({28'h0, ro_en}, 32'h5);
        // own-oscillator sampling on the two live rings still fills the queue
        sclk_sel <= 1'b0;
        xfer(1'b1, OFS_CTRL, 32'h0000_0503);
        repeat (1000) @(posedge pclk);
        rd_chk(OFS_FLVL, 32'hff, DEP);
        results();
    end
endmodule
